// ==== hw/fbo_fifo.v ====
// Flip-flop frame buffer with occupancy count
`timescale 1ns/100ps
`default_nettype none
module fbo_fifo #(
	parameter W = 35,
	parameter DEPTH = 64,
	parameter AW = 6
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire sys_rst_i,
	// Fill side
	input wire push_i,
	input wire [W-1:0] din_i,
	// Drain side
	input wire pop_i,
	output wire [W-1:0] dout_o,
	output wire empty_o,
	output wire full_o,
	output wire [AW:0] count_o
);
	reg [W-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	wire do_push = push_i & ~full_o;
	wire do_pop = pop_i & ~empty_o;

	assign empty_o = (count_ff == {(AW+1){1'b0}});
	assign full_o = (count_ff == DEPTH[AW:0]);
	assign count_o = count_ff;
	assign dout_o = mem_ff[rd_ptr_ff];

	always @(posedge sys_clk_i) begin
		if (do_push) begin
			mem_ff[wr_ptr_ff] <= din_i;
		end
	end

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
			end
			if (do_push & ~do_pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (do_pop & ~do_push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hw/fbo_fill_pct.v ====
// Converts buffer occupancy into percent and half-percent fill levels
`timescale 1ns/100ps
`default_nettype none
`include "fbo_map.vh"
module fbo_fill_pct #(
	parameter DEPTH = 64,
	parameter AW = 6
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire sys_rst_i,
	// Occupancy in entries
	input wire [AW:0] count_i,
	// Registered levels
	output reg [`FBO_PCT_W-1:0] pct_o,
	output reg [`FBO_LVL_W-1:0] half_pct_o
);
	// Divisor held at the product width
	localparam [AW+8:0] DIVISOR = DEPTH[AW+8:0];
	wire [AW+8:0] prod_pct = {8'h00, count_i} * 7'h64;
	wire [AW+8:0] prod_half = {8'h00, count_i} * 8'hC8;
	wire [AW+8:0] quo_pct = prod_pct / DIVISOR;
	wire [AW+8:0] quo_half = prod_half / DIVISOR;

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pct_o <= {`FBO_PCT_W{1'b0}};
			half_pct_o <= {`FBO_LVL_W{1'b0}};
		end else begin
			pct_o <= quo_pct[`FBO_PCT_W-1:0];
			half_pct_o <= quo_half[`FBO_LVL_W-1:0];
		end
	end
endmodule
`default_nettype wire

// ==== hw/fbo_map.vh ====
// Register map, field positions, reset values and widths of the frame buffer block
`ifndef FBO_MAP_VH
`define FBO_MAP_VH

// Register byte offsets
`define FBO_REG_FILL 6'h00
`define FBO_REG_OVF 6'h04
`define FBO_REG_ENTRY 6'h08
`define FBO_REG_EXIT 6'h0C
`define FBO_REG_SYNC 6'h10
`define FBO_REG_IRQ_STAT 6'h14
`define FBO_REG_IRQ_CLR 6'h18
`define FBO_REG_IRQ_EN 6'h1C
`define FBO_REG_EVT 6'h20

// Bus geometry
`define FBO_ADDR_W 6
`define FBO_DATA_W 32

// Threshold levels count in half-percent steps, 200 means 100 percent; the fill level counts whole percent
`define FBO_LVL_W 8
`define FBO_LVL_MAX 8'hC8
`define FBO_ENTRY_RST 8'hC7
`define FBO_EXIT_RST 8'h64
`define FBO_SYNC_RST 8'hA0
`define FBO_PCT_W 7

// Overflow register fields
`define FBO_OVF_FLAG_BIT 0
`define FBO_OVF_STATE_BIT 1

// Interrupt status fields
`define FBO_IRQ_W 3
`define FBO_IRQ_LOST_BIT 0
`define FBO_IRQ_INC_BIT 1
`define FBO_IRQ_OVF_BIT 2
`define FBO_IRQ_EN_RST 3'h0

// Event register fields
`define FBO_EVT_ID_LSB 0
`define FBO_EVT_LOST_BIT 16
`define FBO_EVT_VALID_BIT 17
`define FBO_ID_W 16

`endif

// ==== hw/fbo_top.v ====
// Frame buffer with overflow control between camera input and DMA output
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "fbo_map.vh"
module fbo_top #(
	parameter DW = 32,
	parameter DEPTH = 64,
	parameter AW = 6
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire sys_rst_i,
	// Avalon-MM register slave
	input wire [`FBO_ADDR_W-1:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [`FBO_DATA_W-1:0] avs_writedata_i,
	output wire [`FBO_DATA_W-1:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	// Camera input stream
	input wire cam_valid_i,
	input wire cam_sof_i,
	input wire cam_eof_i,
	input wire [DW-1:0] cam_data_i,
	input wire [`FBO_ID_W-1:0] cam_frame_id_i,
	// DMA output stream
	input wire dma_ready_i,
	output wire dma_valid_o,
	output wire dma_sof_o,
	output wire dma_eof_o,
	output wire dma_incomplete_o,
	output wire [DW-1:0] dma_data_o,
	// Overflow events
	output reg ovf_evt_valid_o,
	output reg ovf_evt_lost_o,
	output reg [`FBO_ID_W-1:0] ovf_evt_id_o,
	// Interrupt
	output wire irq_o
);
	localparam EW = DW + 3;

	// Register state
	reg [`FBO_LVL_W-1:0] entry_lvl_ff;
	reg [`FBO_LVL_W-1:0] exit_lvl_ff;
	reg [`FBO_LVL_W-1:0] sync_lvl_ff;
	reg [`FBO_IRQ_W-1:0] irq_stat_ff;
	reg [`FBO_IRQ_W-1:0] irq_en_ff;
	reg ovf_flag_ff;
	reg [`FBO_DATA_W-1:0] rdata_ff;
	reg ack_ff;
	reg [`FBO_ID_W-1:0] evt_id_ff;
	reg evt_lost_ff;
	reg evt_seen_ff;

	// Frame and overflow state
	reg ovf_st_ff;
	reg in_frame_ff;
	reg term_pend_ff;
	reg [`FBO_ID_W-1:0] cur_id_ff;

	// Buffer wires
	wire fifo_full;
	wire fifo_empty;
	wire [AW:0] fifo_count;
	wire [EW-1:0] fifo_dout;
	wire [`FBO_PCT_W-1:0] fill_pct;
	wire [`FBO_LVL_W-1:0] fill_half;

	// Bus access phases
	wire acc_req = avs_read_i | avs_write_i;
	wire wr_go = avs_write_i & ack_ff;
	wire rd_go = avs_read_i & ack_ff;
	wire rd_ovf = rd_go & (avs_address_i == `FBO_REG_OVF);

	// Threshold decisions
	wire above_entry = fill_half > entry_lvl_ff;
	wire below_exit = fill_half < exit_lvl_ff;
	wire above_sync = fill_half > sync_lvl_ff;
	wire enter_ovf = fifo_full | above_entry;

	// Camera beat classification
	wire beat_sof = cam_valid_i & cam_sof_i;
	wire beat_body = cam_valid_i & ~cam_sof_i & in_frame_ff;
	wire cut_frame = in_frame_ff & (ovf_st_ff | enter_ovf);
	wire sof_drop = ovf_st_ff | enter_ovf | above_sync | term_pend_ff;
	wire sof_take = beat_sof & ~in_frame_ff & ~sof_drop;
	wire sof_lost = beat_sof & ~in_frame_ff & sof_drop;
	wire body_take = beat_body & ~cut_frame;
	wire term_push = term_pend_ff & ~fifo_full & ~in_frame_ff;

	// Buffer write selection
	reg fifo_push;
	reg [EW-1:0] fifo_din;

	always @* begin
		fifo_push = 1'b0;
		fifo_din = {EW{1'b0}};
		if (sof_take | body_take) begin
			fifo_push = 1'b1;
			fifo_din = {cam_sof_i, cam_eof_i, 1'b0, cam_data_i};
		end else if (term_push) begin
			fifo_push = 1'b1;
			fifo_din = {1'b0, 1'b1, 1'b1, {DW{1'b0}}};
		end
	end

	fbo_fifo #(
		.W(EW),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.push_i(fifo_push),
		.din_i(fifo_din),
		.pop_i(dma_ready_i),
		.dout_o(fifo_dout),
		.empty_o(fifo_empty),
		.full_o(fifo_full),
		.count_o(fifo_count)
	);

	fbo_fill_pct #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fill (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.count_i(fifo_count),
		.pct_o(fill_pct),
		.half_pct_o(fill_half)
	);

	// DMA side drains the buffer directly
	assign dma_valid_o = ~fifo_empty;
	assign dma_sof_o = fifo_dout[EW-1];
	assign dma_eof_o = fifo_dout[EW-2];
	assign dma_incomplete_o = fifo_dout[EW-3];
	assign dma_data_o = fifo_dout[DW-1:0];

	// Overflow state with hysteresis
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ovf_st_ff <= 1'b0;
		end else if (ovf_st_ff) begin
			if (below_exit & ~fifo_full) begin
				ovf_st_ff <= 1'b0;
			end
		end else if (enter_ovf) begin
			ovf_st_ff <= 1'b1;
		end
	end

	// Frame tracking and truncation
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			in_frame_ff <= 1'b0;
			term_pend_ff <= 1'b0;
			cur_id_ff <= {`FBO_ID_W{1'b0}};
		end else begin
			if (cut_frame) begin
				in_frame_ff <= 1'b0;
				term_pend_ff <= 1'b1;
			end else if (sof_take) begin
				in_frame_ff <= ~cam_eof_i;
				cur_id_ff <= cam_frame_id_i;
			end else if (body_take & cam_eof_i) begin
				in_frame_ff <= 1'b0;
			end
			if (term_push) begin
				term_pend_ff <= 1'b0;
			end
		end
	end

	// Per-frame overflow events
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ovf_evt_valid_o <= 1'b0;
			ovf_evt_lost_o <= 1'b0;
			ovf_evt_id_o <= {`FBO_ID_W{1'b0}};
		end else if (cut_frame) begin
			ovf_evt_valid_o <= 1'b1;
			ovf_evt_lost_o <= 1'b0;
			ovf_evt_id_o <= cur_id_ff;
		end else if (sof_lost) begin
			ovf_evt_valid_o <= 1'b1;
			ovf_evt_lost_o <= 1'b1;
			ovf_evt_id_o <= cam_frame_id_i;
		end else begin
			ovf_evt_valid_o <= 1'b0;
		end
	end

	// Last event kept for software
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			evt_id_ff <= {`FBO_ID_W{1'b0}};
			evt_lost_ff <= 1'b0;
			evt_seen_ff <= 1'b0;
		end else if (ovf_evt_valid_o) begin
			evt_id_ff <= ovf_evt_id_o;
			evt_lost_ff <= ovf_evt_lost_o;
			evt_seen_ff <= 1'b1;
		end
	end

	// Clear-on-read overflow flag, new entry beats the read
	wire ovf_entry = ~ovf_st_ff & enter_ovf;

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ovf_flag_ff <= 1'b0;
		end else if (ovf_entry) begin
			ovf_flag_ff <= 1'b1;
		end else if (rd_ovf) begin
			ovf_flag_ff <= 1'b0;
		end
	end

	// Interrupt status, set wins over clear
	wire [`FBO_IRQ_W-1:0] irq_set;
	wire [`FBO_IRQ_W-1:0] irq_clr;

	assign irq_set[`FBO_IRQ_LOST_BIT] = sof_lost;
	assign irq_set[`FBO_IRQ_INC_BIT] = cut_frame;
	assign irq_set[`FBO_IRQ_OVF_BIT] = ovf_entry;
	assign irq_clr = (wr_go & (avs_address_i == `FBO_REG_IRQ_CLR)) ?
		avs_writedata_i[`FBO_IRQ_W-1:0] : {`FBO_IRQ_W{1'b0}};

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			irq_stat_ff <= {`FBO_IRQ_W{1'b0}};
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
		end
	end

	assign irq_o = |(irq_stat_ff & irq_en_ff);

	// Bus handshake: one wait state per access
	assign avs_waitrequest_o = acc_req & ~ack_ff;
	assign avs_readdata_o = rdata_ff;

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= acc_req & ~ack_ff;
		end
	end

	// Register writes
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			entry_lvl_ff <= `FBO_ENTRY_RST;
			exit_lvl_ff <= `FBO_EXIT_RST;
			sync_lvl_ff <= `FBO_SYNC_RST;
			irq_en_ff <= `FBO_IRQ_EN_RST;
		end else if (wr_go) begin
			case (avs_address_i)
				`FBO_REG_ENTRY: begin
					entry_lvl_ff <= lvl_clip(avs_writedata_i[`FBO_LVL_W-1:0]);
				end
				`FBO_REG_EXIT: begin
					exit_lvl_ff <= lvl_clip(avs_writedata_i[`FBO_LVL_W-1:0]);
				end
				`FBO_REG_SYNC: begin
					sync_lvl_ff <= lvl_clip(avs_writedata_i[`FBO_LVL_W-1:0]);
				end
				`FBO_REG_IRQ_EN: begin
					irq_en_ff <= avs_writedata_i[`FBO_IRQ_W-1:0];
				end
				default: begin
					irq_en_ff <= irq_en_ff;
				end
			endcase
		end
	end

	// Levels above 100 percent saturate
	function [`FBO_LVL_W-1:0] lvl_clip;
		input [`FBO_LVL_W-1:0] v;
		begin
			lvl_clip = (v > `FBO_LVL_MAX) ? `FBO_LVL_MAX : v;
		end
	endfunction

	// Read data mux
	reg [`FBO_DATA_W-1:0] nxt_rdata;

	always @* begin
		nxt_rdata = {`FBO_DATA_W{1'b0}};
		case (avs_address_i)
			`FBO_REG_FILL: begin
				nxt_rdata[`FBO_PCT_W-1:0] = fill_pct;
			end
			`FBO_REG_OVF: begin
				nxt_rdata[`FBO_OVF_FLAG_BIT] = ovf_flag_ff | ovf_entry;
				nxt_rdata[`FBO_OVF_STATE_BIT] = ovf_st_ff;
			end
			`FBO_REG_ENTRY: begin
				nxt_rdata[`FBO_LVL_W-1:0] = entry_lvl_ff;
			end
			`FBO_REG_EXIT: begin
				nxt_rdata[`FBO_LVL_W-1:0] = exit_lvl_ff;
			end
			`FBO_REG_SYNC: begin
				nxt_rdata[`FBO_LVL_W-1:0] = sync_lvl_ff;
			end
			`FBO_REG_IRQ_STAT: begin
				nxt_rdata[`FBO_IRQ_W-1:0] = irq_stat_ff;
			end
			`FBO_REG_IRQ_EN: begin
				nxt_rdata[`FBO_IRQ_W-1:0] = irq_en_ff;
			end
			`FBO_REG_EVT: begin
				nxt_rdata[`FBO_EVT_ID_LSB+`FBO_ID_W-1:`FBO_EVT_ID_LSB] = evt_id_ff;
				nxt_rdata[`FBO_EVT_LOST_BIT] = evt_lost_ff;
				nxt_rdata[`FBO_EVT_VALID_BIT] = evt_seen_ff;
			end
			default: begin
				nxt_rdata = {`FBO_DATA_W{1'b0}};
			end
		endcase
	end

	// Read data captured in the wait cycle, stands at the completing edge
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rdata_ff <= {`FBO_DATA_W{1'b0}};
		end else if (avs_read_i & ~ack_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end
endmodule
`default_nettype wire

// ==== test/fbo_chk.sv ====
// Port-level assertions for the frame buffer block
`timescale 1ns/100ps
`default_nettype none
module fbo_chk #(
	parameter DW = 32
) (
	// Clock, reset and register bus
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Streams, events and interrupt
	input wire logic cam_valid_i,
	input wire logic cam_sof_i,
	input wire logic [DW-1:0] cam_data_i,
	input wire logic dma_ready_i,
	input wire logic dma_valid_o,
	input wire logic dma_sof_o,
	input wire logic dma_eof_o,
	input wire logic dma_incomplete_o,
	input wire logic [DW-1:0] dma_data_o,
	input wire logic ovf_evt_valid_o,
	input wire logic ovf_evt_lost_o,
	input wire logic irq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_pass_thru: assert property ((!dma_valid_o) [*3] ##0 (cam_valid_i && cam_sof_i)
		|=> dma_valid_o && dma_sof_o && dma_data_o == $past(cam_data_i)) else $error("no pass");
	a_term_beat: assert property (dma_valid_o && dma_incomplete_o
		|-> dma_eof_o && !dma_sof_o && dma_data_o == '0) else $error("bad terminator");
	a_head_hold: assert property (dma_valid_o && !dma_ready_i |=> dma_valid_o &&
		$stable({dma_sof_o, dma_eof_o, dma_incomplete_o, dma_data_o})) else $error("head moved");
	a_evt_cause: assert property (ovf_evt_valid_o
		|-> $past(cam_valid_i) || $past(cam_valid_i, 2)) else $error("event without beat");
	a_lost_sof: assert property (ovf_evt_valid_o && ovf_evt_lost_o
		|-> $past(cam_sof_i) || $past(cam_sof_i, 2)) else $error("lost without sof");
	a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("wait not one");
	a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
		else $error("no wait state");
	a_rd_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("rdata moved");
	a_rst_idle: assert property ($fell(sys_rst_i) |-> !dma_valid_o && !irq_o && !ovf_evt_valid_o)
		else $error("not idle");
	c_term: cover property (dma_valid_o && dma_incomplete_o && dma_ready_i);
	c_lost: cover property (ovf_evt_valid_o && ovf_evt_lost_o);
	c_irq: cover property ($rose(irq_o));
endmodule
bind fbo_top fbo_chk #(.DW(DW)) u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .cam_valid_i(cam_valid_i), .cam_sof_i(cam_sof_i),
	.cam_data_i(cam_data_i), .dma_ready_i(dma_ready_i), .dma_valid_o(dma_valid_o),
	.dma_sof_o(dma_sof_o), .dma_eof_o(dma_eof_o), .dma_incomplete_o(dma_incomplete_o),
	.dma_data_o(dma_data_o), .ovf_evt_valid_o(ovf_evt_valid_o),
	.ovf_evt_lost_o(ovf_evt_lost_o), .irq_o(irq_o));
`default_nettype wire

// ==== test/fbo_dma_sink.sv ====
// Host DMA consumer model, prompt, slow or stalled
`timescale 1ns/100ps
`default_nettype none
module fbo_dma_sink (
	// Clock, reset and pacing
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic stall_i,
	input wire logic slow_i,
	// Stream and tallies
	input wire logic valid_i,
	input wire logic sof_i,
	input wire logic inc_i,
	output logic ready_o,
	output logic [7:0] n_sof_o,
	output logic [7:0] n_inc_o
);
	logic phase_ff;
	assign ready_o = !stall_i && (!slow_i || phase_ff);
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			phase_ff <= 1'b0;
			n_sof_o <= 8'h00;
			n_inc_o <= 8'h00;
		end else begin
			phase_ff <= !phase_ff;
			if (valid_i && ready_o) begin
				n_sof_o <= n_sof_o + {7'h00, sof_i};
				n_inc_o <= n_inc_o + {7'h00, inc_i};
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the frame buffer block
`timescale 1ns/100ps
`default_nettype none
`include "fbo_map.vh"
module tb;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [5:0] adr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic cv = 1'b0;
	logic cs = 1'b0;
	logic ce = 1'b0;
	logic [31:0] cd = 32'h0;
	logic [15:0] cid = 16'h0;
	logic stall = 1'b0;
	logic slow = 1'b0;
	wire [31:0] rdat;
	wire wreq, rdy, dv, ds, de, dinc, ev_v, ev_l, irq;
	wire [31:0] ddat;
	wire [15:0] ev_id;
	wire [7:0] n_sof, n_inc;
	integer bad_count = 0;
	integer n_checks = 0;
	integer ev_n = 0;
	integer i;
	logic ev_lost = 1'b0;
	logic [15:0] ev_idl = 16'h0;
	logic [31:0] rv;
	// Write flag, address, write data, expected read
	logic [70:0] rows [0:16] = '{{1'b0, 6'h00, 32'h0, 32'h0}, {1'b0, 6'h04, 32'h0, 32'h0},
		{1'b0, 6'h08, 32'h0, 32'hC7}, {1'b0, 6'h0C, 32'h0, 32'h64}, {1'b0, 6'h10, 32'h0, 32'hA0},
		{1'b0, 6'h14, 32'h0, 32'h0}, {1'b0, 6'h18, 32'h0, 32'h0}, {1'b0, 6'h1C, 32'h0, 32'h0},
		{1'b0, 6'h20, 32'h0, 32'h0}, {1'b0, 6'h3C, 32'h0, 32'h0}, {1'b1, 6'h08, 32'hFF, 32'hC8},
		{1'b1, 6'h08, 32'hC7, 32'hC7}, {1'b1, 6'h00, 32'h7F, 32'h0}, {1'b1, 6'h3C, 32'hFF, 32'h0},
		{1'b1, 6'h18, 32'h7, 32'h0}, {1'b1, 6'h10, 32'h1C9, 32'hC8},
		{1'b1, 6'h10, 32'hA0, 32'hA0}};
	always #4 sys_clk_i = ~sys_clk_i;
	fbo_top #(.DW(32), .DEPTH(8), .AW(3)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .cam_valid_i(cv), .cam_sof_i(cs),
		.cam_eof_i(ce), .cam_data_i(cd), .cam_frame_id_i(cid), .dma_ready_i(rdy),
		.dma_valid_o(dv), .dma_sof_o(ds), .dma_eof_o(de), .dma_incomplete_o(dinc),
		.dma_data_o(ddat), .ovf_evt_valid_o(ev_v), .ovf_evt_lost_o(ev_l),
		.ovf_evt_id_o(ev_id), .irq_o(irq));
	fbo_dma_sink u_sink (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .stall_i(stall),
		.slow_i(slow), .valid_i(dv), .sof_i(ds), .inc_i(dinc), .ready_o(rdy),
		.n_sof_o(n_sof), .n_inc_o(n_inc));
	always @(posedge sys_clk_i) begin
		if (ev_v === 1'b1) begin
			ev_n <= ev_n + 1;
			ev_lost <= ev_l;
			ev_idl <= ev_id;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		integer k;
		@(posedge sys_clk_i);
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		k = 0;
		do begin
			@(posedge sys_clk_i);
			k = k + 1;
		end while (wreq !== 1'b0 && k < 20);
		rv = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		chk(k < 20, 1);
	endtask
	task automatic frame(input logic [15:0] id, input integer n);
		integer j;
		for (j = 0; j < n; j++) begin
			@(posedge sys_clk_i);
			cv <= 1'b1;
			cs <= (j == 0);
			ce <= (j == n - 1);
			cd <= {id, j[15:0]};
			cid <= id;
		end
		@(posedge sys_clk_i);
		cv <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
	endtask
	task automatic drain;
		integer k;
		stall <= 1'b0;
		k = 0;
		while (dv !== 1'b0 && k < 100) begin
			@(posedge sys_clk_i);
			k = k + 1;
		end
		chk(k < 100, 1);
		repeat (4) @(posedge sys_clk_i);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count = bad_count + 1;
		give_verdict;
	end
	initial begin
		repeat (16) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		for (i = 0; i < 17; i++) begin
			if (rows[i][70])
				bus(1'b1, rows[i][69:64], rows[i][63:32]);
			bus(1'b0, rows[i][69:64], 32'h0);
			chk(rv, rows[i][31:0]);
		end
		$display("registers done");
		slow <= 1'b1;
		frame(16'h0005, 3);
		drain;
		chk({n_sof, ev_n[7:0]}, {8'h01, 8'h00});
		$display("pass-through done");
		stall <= 1'b1;
		frame(16'h0001, 7);
		frame(16'h0002, 2);
		chk({ev_n[3:0], ev_lost, ev_idl}, {4'h1, 1'b1, 16'h0002});
		bus(1'b0, `FBO_REG_OVF, 32'h0);
		chk(rv, 32'h0);
		drain;
		chk(n_sof, 2);
		$display("frame-sync drop done");
		stall <= 1'b1;
		frame(16'h0009, 10);
		chk({ev_n[3:0], ev_lost, ev_idl}, {4'h2, 1'b0, 16'h0009});
		bus(1'b0, `FBO_REG_FILL, 32'h0);
		chk(rv, 32'h64);
		bus(1'b0, `FBO_REG_OVF, 32'h0);
		chk(rv, 32'h3);
		bus(1'b0, `FBO_REG_OVF, 32'h0);
		chk(rv, 32'h2);
		frame(16'h000B, 2);
		chk({ev_n[3:0], ev_lost, ev_idl}, {4'h3, 1'b1, 16'h000B});
		bus(1'b0, `FBO_REG_EVT, 32'h0);
		chk(rv, 32'h0003000B);
		drain;
		chk({n_sof, n_inc}, {8'h03, 8'h01});
		bus(1'b0, `FBO_REG_OVF, 32'h0);
		chk(rv, 32'h0);
		frame(16'h000C, 3);
		drain;
		chk(n_sof, 4);
		$display("overflow done");
		bus(1'b0, `FBO_REG_IRQ_STAT, 32'h0);
		chk(rv, 32'h7);
		chk(irq, 0);
		bus(1'b1, `FBO_REG_IRQ_EN, 32'h4);
		@(negedge sys_clk_i);
		chk(irq, 1);
		bus(1'b1, `FBO_REG_IRQ_CLR, 32'h4);
		@(negedge sys_clk_i);
		chk(irq, 0);
		bus(1'b0, `FBO_REG_IRQ_STAT, 32'h0);
		chk(rv, 32'h3);
		$display("interrupt done");
		bus(1'b1, `FBO_REG_EXIT, 32'h20);
		bus(1'b0, `FBO_REG_EXIT, 32'h0);
		chk(rv, 32'h20);
		sys_rst_i <= 1'b1;
		repeat (16) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		bus(1'b0, `FBO_REG_EXIT, 32'h0);
		chk(rv, 32'h64);
		bus(1'b0, `FBO_REG_IRQ_STAT, 32'h0);
		chk(rv, 32'h0);
		chk({dv, irq}, 2'h0);
		$display("reset done");
		give_verdict;
	end
endmodule
`default_nettype wire
